// ---- bench/icsfp_fetch_sva.sv ----
`timescale 1ns/10ps
module icsfp_fetch_sva (
	input wire        clk_sys,
	input wire        reset,
	input wire        fetchReq,
	input wire [31:0] fetchAddr,
	input wire        fetchReady,
	input wire        fetchValid,
	input wire        fetchTrap,
	input wire        memReq,
	input wire [31:0] memAddr,
	input wire        predReq,
	input wire        predValid,
	input wire        updValid,
	input wire        updMispredict,
	input wire        redirectValid,
	input wire        dataReq,
	input wire        dataAck,
	input wire        dataErr
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	// a fetch taken this edge
	wire take = fetchReq && fetchReady;

	odd_trap_a: assert property (take && fetchAddr[0] |=> fetchValid && fetchTrap)
		else $error("odd fetch address not trapped");
	low_trap_a: assert property (take && fetchAddr[31:28] == 4'h0 |=> fetchTrap)
		else $error("non-executable fetch not trapped");
	take_answer_a: assert property (take |=> fetchValid || memReq)
		else $error("fetch neither answered nor filling");
	line_align_a: assert property (memReq |-> memAddr[4:0] == 5'h00 && !fetchReady)
		else $error("fill address not line aligned");
	one_burst_a: assert property (memReq |=> !memReq [*8])
		else $error("second fill during burst");
	spad_fast_a: assert property (take && fetchAddr[31:13] == 19'h08000 |=> fetchValid && !memReq)
		else $error("scratchpad fetch slow or filling");
	pred_lat_a: assert property (predReq |=> predValid)
		else $error("prediction late");
	mispred_a: assert property (updValid && updMispredict |=> !fetchReady [*2] ##1 redirectValid)
		else $error("mispredict penalty wrong");
	data_ack_a: assert property (dataAck |-> $past(dataReq) && $past(dataReq, 2))
		else $error("data ack without held request");

	cover property (memReq);
	cover property (redirectValid);
	cover property (dataAck && !dataErr);
	cover property (fetchValid && fetchTrap);
endmodule

bind icsfp_fetch icsfp_fetch_sva u_sva (.clk_sys, .reset, .fetchReq, .fetchAddr, .fetchReady,
	.fetchValid, .fetchTrap, .memReq, .memAddr, .predReq, .predValid, .updValid,
	.updMispredict, .redirectValid, .dataReq, .dataAck, .dataErr);

// ---- bench/icsfp_mem_model.sv ----
`timescale 1ns/10ps
module icsfp_mem_model (
	input  wire        clk_sys,
	input  wire        reset,
	input  wire        slow,
	input  wire        memReq,
	input  wire [31:0] memAddr,
	output reg         memBeatValid,
	output reg  [31:0] memBeatData
);
	reg [3:0]  left;
	reg [31:0] addr;
	reg        gap;
	// eight ascending words per burst, idle gaps when slow
	always @(posedge clk_sys) begin
		memBeatValid <= 1'b0;
		memBeatData <= ~memBeatData; // released bus keeps toggling
		gap <= slow & ~gap;
		if (reset) begin
			left <= 4'h0;
			memBeatData <= 32'h00000000;
		end else if (memReq) begin
			left <= 4'h8;
			addr <= memAddr;
		end else if (left != 4'h0 && !gap) begin
			memBeatValid <= 1'b1;
			memBeatData <= ~addr;
			addr <= addr + 32'h00000004;
			left <= left - 4'h1;
		end
	end
endmodule

// ---- bench/tb_icsfp_fetch.sv ----
`timescale 1ns/10ps
module tb_icsfp_fetch;
	reg         clk_sys = 1'b0;
	reg         reset = 1'b1;
	reg         slow = 1'b0;
	reg         fetchReq = 1'b0;
	reg  [31:0] fetchAddr = 32'h00000000;
	reg         fenceI = 1'b0;
	reg         dataReq = 1'b0;
	reg         dataWrite = 1'b0;
	reg  [31:0] dataAddr = 32'h00000000;
	reg  [31:0] dataWrData = 32'h00000000;
	reg  [3:0]  dataByteEn = 4'hF;
	reg         predReq = 1'b0;
	reg  [31:0] predPc = 32'h00000000;
	reg         updValid = 1'b0;
	reg  [31:0] updPc = 32'h00000000;
	reg  [31:0] updTarget = 32'h00000000;
	reg  [5:0]  updFlags = 6'h00;
	wire        fetchReady, fetchValid, fetchTrap, dataAck, dataErr, memReq, memBeatValid;
	wire        predValid, predTaken, redirectValid;
	wire [31:0] fetchInstr, dataRdData, memAddr, memBeatData, predTarget, redirectPc;
	integer     fails;
	integer     total_checks;

	icsfp_fetch dut (.clk_sys, .reset, .fetchReq, .fetchAddr, .fetchReady, .fetchValid,
		.fetchTrap, .fetchInstr, .fenceI, .dataReq, .dataWrite, .dataAddr, .dataByteEn,
		.dataWrData, .dataAck, .dataErr, .dataRdData, .memReq, .memAddr, .memBeatValid,
		.memBeatData, .predReq, .predPc, .predValid, .predTaken, .predTarget, .updValid,
		.updPc, .updTarget, .updTaken(updFlags[5]), .updCond(updFlags[4]),
		.updCall(updFlags[3]), .updRet(updFlags[2]), .updCompressed(updFlags[1]),
		.updMispredict(updFlags[0]), .redirectValid, .redirectPc);
	icsfp_mem_model mem (.clk_sys, .reset, .slow, .memReq, .memAddr, .memBeatValid,
		.memBeatData);

	always #10 clk_sys = ~clk_sys;

	// word the memory model returns
	function [31:0] mw(input [31:0] a);
		mw = ~{a[31:2], 2'b00};
	endfunction
	task automatic check(input [31:0] got, input [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		if (fails == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic guard(input integer i);
		if (i >= 200) begin
			fails = fails + 1;
			finish_test;
		end
	endtask
	// one fetch: cycles to answer, fill seen, trap, word
	task automatic fetch(input [31:0] a, output integer n, output logic m, output logic tr,
		output logic [31:0] ins);
		n = 0;
		do begin
			@(negedge clk_sys);
			n = n + 1;
		end while (fetchReady !== 1'b1 && n < 200);
		guard(n);
		fetchReq = 1'b1;
		fetchAddr = a;
		@(negedge clk_sys);
		fetchReq = 1'b0;
		n = 1;
		m = memReq;
		while (fetchValid !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n = n + 1;
			m = m | memReq;
		end
		guard(n);
		tr = fetchTrap;
		ins = fetchInstr;
	endtask
	task automatic fchk(input [31:0] a, input em, input et, input [31:0] ei);
		integer n;
		logic m, tr;
		logic [31:0] ins;
		fetch(a, n, m, tr, ins);
		check(m, em);
		check(n == 1, !em);
		check(tr, et);
		if (em) check(memAddr, {a[31:5], 5'h00});
		if (!et) check(ins, ei);
	endtask
	// data access, ack two cycles after request
	task automatic dacc(input w, input [31:0] a, input [31:0] d, input ee, input [31:0] er);
		integer i;
		dataReq = 1'b1;
		dataWrite = w;
		dataAddr = a;
		dataWrData = d;
		i = 0;
		do begin
			@(negedge clk_sys);
			i = i + 1;
		end while (dataAck !== 1'b1 && i < 200);
		guard(i);
		check(i, 2);
		check(dataErr, ee);
		if (!w && !ee) check(dataRdData, er);
		@(negedge clk_sys);
		dataReq = 1'b0;
		@(negedge clk_sys);
	endtask
	// flags: taken, cond, call, ret, compressed, mispredict
	task automatic upd(input [31:0] pc, input [31:0] tg, input [5:0] f);
		@(negedge clk_sys);
		updValid = 1'b1;
		updPc = pc;
		updTarget = tg;
		updFlags = f;
		@(negedge clk_sys);
		updValid = 1'b0;
	endtask
	task automatic pchk(input [31:0] pc, input et, input [31:0] etg);
		@(negedge clk_sys);
		predReq = 1'b1;
		predPc = pc;
		@(negedge clk_sys);
		predReq = 1'b0;
		check(predValid, 1);
		check(predTaken, et);
		if (et) check(predTarget, etg);
	endtask
	// both ways of a set, compressed half, fence
	task automatic t_cache;
		fchk(32'h20000104, 1, 0, mw(32'h20000104));
		slow = 1'b1;
		fchk(32'h20002104, 1, 0, mw(32'h20002104));
		slow = 1'b0;
		fchk(32'h20000106, 0, 0, mw(32'h20000104));
		fchk(32'h20002104, 0, 0, mw(32'h20002104));
		fchk(32'h2000011C, 0, 0, mw(32'h2000011C));
		@(negedge clk_sys);
		fenceI = 1'b1;
		@(negedge clk_sys);
		fenceI = 1'b0;
		fchk(32'h20000104, 1, 0, mw(32'h20000104));
	endtask
	task automatic t_trap;
		fchk(32'h20000101, 0, 1, 0);
		fchk(32'h00000100, 0, 1, 0);
		fchk(32'h40000000, 0, 1, 0);
		fchk(32'h10000000, 0, 1, 0);
	endtask
	task automatic t_mis;
		upd(32'h20000600, 32'h20000A00, 6'h21);
		check(fetchReady, 0);
		@(negedge clk_sys);
		check(fetchReady, 0);
		@(negedge clk_sys);
		check(redirectValid, 1);
		check(redirectPc, 32'h20000A00);
		check(fetchReady, 1);
	endtask
	task automatic t_pred;
		upd(32'h20000200, 32'h20000300, 6'h20);
		pchk(32'h20000200, 1, 32'h20000300);
		pchk(32'h20000204, 0, 0);
		upd(32'h20000500, 32'h20000900, 6'h24);
		upd(32'h20000400, 32'h20000700, 6'h2A);
		pchk(32'h20000500, 1, 32'h20000402);
		upd(32'h20000800, 32'h20000880, 6'h30);
		pchk(32'h20000800, 1, 32'h20000880);
		upd(32'h20000800, 32'h20000880, 6'h10);
		pchk(32'h20000800, 0, 0);
	endtask
	// allocate, use, refuse, free the scratchpad
	task automatic t_spad;
		integer n;
		logic m1, m2, tr;
		logic [31:0] ins;
		fchk(32'h20000020, 1, 0, mw(32'h20000020));
		fchk(32'h20002020, 1, 0, mw(32'h20002020));
		dacc(1, 32'h10000044, 32'hC0DE1234, 0, 0);
		fetch(32'h20000020, n, m1, tr, ins);
		fetch(32'h20002020, n, m2, tr, ins);
		check(m1 | m2, 1);
		fchk(32'h10000044, 0, 0, 32'hC0DE1234);
		fchk(32'h10000060, 0, 1, 0);
		dacc(1, 32'h10000000, 32'h5A5A0F0F, 0, 0);
		fchk(32'h10000000, 0, 0, 32'h5A5A0F0F);
		dacc(0, 32'h10000044, 0, 0, 32'hC0DE1234);
		dataByteEn = 4'h3;
		dacc(1, 32'h10000000, 32'hFFFFFFFF, 0, 0);
		dataByteEn = 4'hF;
		dacc(0, 32'h10000000, 0, 0, 32'h5A5AFFFF);
		dacc(1, 32'h10003000, 32'h00000001, 1, 0);
		fchk(32'h20004000, 1, 0, mw(32'h20004000));
		dacc(1, 32'h10002000, 0, 0, 0);
		fchk(32'h10000044, 0, 1, 0);
		fetch(32'h20006000, n, m1, tr, ins);
		fchk(32'h20004000, 0, 0, mw(32'h20004000));
		fchk(32'h20006000, 0, 0, mw(32'h20006000));
	endtask

	initial begin
		fails = 0;
		total_checks = 0;
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		t_cache;
		t_trap;
		t_mis;
		t_pred;
		t_spad;
		finish_test;
	end
endmodule

// ---- verilog/icsfp_fetch.v ----
// Overview of operation
// - 16 KiB two-way set-associative instruction cache
// - every hit or trap answers one cycle later; a miss answers after its burst fill
// - no coherence; fence invalidates every cache line
// - 32-byte lines filled by one burst
// - cache executable fetches, never scratchpad ones
// - non-executable fetch raises synchronous trap
// - scratchpad fetch fast as hit, never misses
// - scratchpad also serves slower data loads/stores
// - scratchpad holds at most 8 KiB
// - scratchpad taken from way one, line units
// - store in line n allocates lines 0 to n
// - zero store past region frees scratchpad
// - freed lines return to cache automatically
// - 28-entry target buffer predicts taken targets
// - 512-entry direction table predicts conditional branches
// - 6-entry return stack predicts return targets
// - prediction one cycle, correct ones cost nothing
// - misprediction costs three cycles before redirect
// - 16-bit compressed instructions mixed with full
`timescale 1ns/10ps
`include "icsfp_regs.vh"
module icsfp_fetch #(
	parameter BTB_N = `ICSFP_BTB_N,
	parameter BHT_N = `ICSFP_BHT_N,
	parameter BHT_W = `ICSFP_BHT_W,
	parameter RAS_N = `ICSFP_RAS_N
)(
	input  wire        clk_sys,
	input  wire        reset,
	input  wire        fetchReq,
	input  wire [31:0] fetchAddr,
	output reg         fetchReady,
	output reg         fetchValid,
	output reg         fetchTrap,
	output wire [31:0] fetchInstr,
	input  wire        fenceI,
	input  wire        dataReq,
	input  wire        dataWrite,
	input  wire [31:0] dataAddr,
	input  wire [3:0]  dataByteEn,
	input  wire [31:0] dataWrData,
	output reg         dataAck,
	output reg         dataErr,
	output reg  [31:0] dataRdData,
	output reg         memReq,
	output reg  [31:0] memAddr,
	input  wire        memBeatValid,
	input  wire [31:0] memBeatData,
	input  wire        predReq,
	input  wire [31:0] predPc,
	output reg         predValid,
	output reg         predTaken,
	output reg  [31:0] predTarget,
	input  wire        updValid,
	input  wire [31:0] updPc,
	input  wire [31:0] updTarget,
	input  wire        updTaken,
	input  wire        updCond,
	input  wire        updCall,
	input  wire        updRet,
	input  wire        updCompressed,
	input  wire        updMispredict,
	output reg         redirectValid,
	output reg  [31:0] redirectPc
);
	localparam [1:0] S_RUN    = 2'h0;
	localparam [1:0] S_FILL   = 2'h1;
	localparam [1:0] S_REPLAY = 2'h2;
	localparam [1:0] PEN_LOAD = `ICSFP_MISPRED_CYC - 1;
	localparam [31:0] FREE_ADDR = `ICSFP_SPAD_BASE + `ICSFP_SPAD_BYTES;
	localparam [4:0] BTB_LAST = BTB_N - 1;
	localparam [2:0] RAS_LAST = RAS_N - 1;
	localparam [2:0] RAS_FULL = RAS_N;

	reg  [1:0]  state;
	reg  [18:0] tag0 [0:`ICSFP_SETS-1];
	reg  [18:0] tag1 [0:`ICSFP_SETS-1];
	wire [`ICSFP_SETS-1:0] valid0;
	wire [`ICSFP_SETS-1:0] valid1;
	reg  [`ICSFP_SETS-1:0] lru;
	reg  [8:0]  spadLines;
	reg  [31:0] missAddr;
	reg  [2:0]  beatCnt;
	reg         victim;
	reg  [1:0]  penCnt;
	reg         dataBusy;

	// fetch address decode
	wire [7:0]  fSet     = fetchAddr[`ICSFP_SET_MSB:`ICSFP_SET_LSB];
	wire [18:0] fTag     = fetchAddr[31:`ICSFP_TAG_LSB];
	wire        fInSpad  = fTag == `ICSFP_SPAD_BASE >> `ICSFP_TAG_LSB;
	wire        fSpadOk  = fInSpad && ({1'b0, fSet} < spadLines);
	wire        fExec    = fetchAddr >= `ICSFP_EXEC_BASE && fetchAddr <= `ICSFP_EXEC_LIMIT;
	wire        hit0     = valid0[fSet] && tag0[fSet] == fTag;
	wire        hit1     = valid1[fSet] && tag1[fSet] == fTag;
	wire        fetchTake = fetchReq && fetchReady;
	// odd byte address, unallocated scratchpad line or outside both windows traps; bit 1 is legal
	wire        fTrap    = fetchAddr[0] || (fInSpad ? !fSpadOk : !fExec);
	wire        fHit     = fInSpad ? fSpadOk : (hit0 || hit1);
	wire        fWay     = fInSpad ? `ICSFP_SPAD_WAY : hit1;
	wire        fSpadWay = {1'b0, fSet} < spadLines;
	wire        fVictim  = fSpadWay ? 1'b0 : lru[fSet];
	wire        goFill   = state == S_RUN && fetchTake && !fTrap && !fHit;
	wire        fillDone = state == S_FILL && memBeatValid && beatCnt == `ICSFP_LAST_BEAT;
	wire [7:0]  mSet     = missAddr[`ICSFP_SET_MSB:`ICSFP_SET_LSB];

	// data port decode
	wire        dInSpad  = dataAddr[31:`ICSFP_TAG_LSB] == `ICSFP_SPAD_BASE >> `ICSFP_TAG_LSB;
	wire        dIsFree  = dataAddr == FREE_ADDR;
	wire [7:0]  dLine    = dataAddr[`ICSFP_SET_MSB:`ICSFP_SET_LSB];
	wire        dataTake = dataReq && !dataBusy && !dataAck && state == S_RUN && !fetchTake;
	wire [8:0]  dAlloc   = {1'b0, dLine} + 9'h001;

	// misprediction penalty countdown
	wire        misNow   = updValid && updMispredict;
	wire [1:0]  penNext  = misNow ? PEN_LOAD : (penCnt != 2'h0 ? penCnt - 2'h1 : 2'h0);

	// storage port arbitration: fill, replay, fetch, then data
	reg         ramEn;
	reg         ramWe;
	reg  [3:0]  ramBe;
	reg  [11:0] ramAddr;
	reg  [31:0] ramWd;
	wire [31:0] ramDout;
	always @* begin
		ramEn = 1'b0;
		ramWe = 1'b0;
		ramBe = 4'hF;
		ramAddr = 12'h000;
		ramWd = memBeatData;
		if (state == S_FILL) begin
			ramEn = memBeatValid;
			ramWe = 1'b1;
			ramAddr = {victim, mSet, beatCnt};
		end else if (state == S_REPLAY) begin
			ramEn = 1'b1;
			ramAddr = {victim, mSet, missAddr[4:2]};
		end else if (fetchTake && fHit && !fTrap) begin
			ramEn = 1'b1;
			ramAddr = {fWay, fSet, fetchAddr[4:2]};
		end else if (dataTake && dInSpad) begin
			ramEn = 1'b1;
			ramWe = dataWrite;
			ramBe = dataByteEn;
			ramAddr = {`ICSFP_SPAD_WAY, dLine, dataAddr[4:2]};
			ramWd = dataWrData;
		end
	end

	// both ways share one array; way bit is the address msb
	icsfp_ram #(
		.AW (`ICSFP_RAM_AW),
		.NB (4)
	) u_store (
		.clk_sys (clk_sys),
		.en      (ramEn),
		.we      (ramWe),
		.be      (ramBe),
		.addr    (ramAddr),
		.wdata   (ramWd),
		.rdata   (ramDout)
	);
	assign fetchInstr = ramDout;

	// per-set valid bits; fence clears all, scratch lines drop out
	genvar gi;
	generate
		for (gi = 0; gi < `ICSFP_SETS; gi = gi + 1) begin : g_set
			localparam [8:0] IDX = gi;
			reg v0;
			reg v1;
			always @(posedge clk_sys) begin
				if (reset || fenceI) begin
					v0 <= 1'b0;
					v1 <= 1'b0;
				end else begin
					if (fillDone && mSet == IDX[7:0] && !victim) begin
						v0 <= 1'b1;
					end
					if (IDX < spadLines) begin
						v1 <= 1'b0;
					end else if (fillDone && mSet == IDX[7:0] && victim) begin
						v1 <= 1'b1;
					end
				end
			end
			assign valid0[gi] = v0;
			assign valid1[gi] = v1;
		end
	endgenerate

	// tags and replacement order
	always @(posedge clk_sys) begin
		if (reset) begin
			lru <= {`ICSFP_SETS{1'b0}};
		end else if (fillDone) begin
			if (victim) begin
				tag1[mSet] <= missAddr[31:`ICSFP_TAG_LSB];
			end else begin
				tag0[mSet] <= missAddr[31:`ICSFP_TAG_LSB];
			end
			lru[mSet] <= !victim;
		end else if (state == S_RUN && fetchTake && fHit && !fTrap && !fInSpad) begin
			lru[fSet] <= !fWay;
		end
	end

	// fetch sequencer: hit, trap, burst fill, replay
	always @(posedge clk_sys) begin
		if (reset) begin
			state <= S_RUN;
			fetchReady <= 1'b0;
			fetchValid <= 1'b0;
			fetchTrap <= 1'b0;
			memReq <= 1'b0;
			memAddr <= 32'h00000000;
			missAddr <= 32'h00000000;
			beatCnt <= 3'h0;
			victim <= 1'b0;
			penCnt <= 2'h0;
			redirectValid <= 1'b0;
			redirectPc <= 32'h00000000;
		end else begin
			fetchValid <= 1'b0;
			fetchTrap <= 1'b0;
			memReq <= 1'b0;
			case (state)
			S_RUN: begin
				if (fetchTake && fTrap) begin
					fetchValid <= 1'b1;
					fetchTrap <= 1'b1;
				end else if (fetchTake && fHit) begin
					fetchValid <= 1'b1;
				end else if (goFill) begin
					state <= S_FILL;
					memReq <= 1'b1;
					memAddr <= {fetchAddr[31:`ICSFP_SET_LSB], 5'h00};
					missAddr <= fetchAddr;
					victim <= fVictim;
					beatCnt <= 3'h0;
				end
			end
			S_FILL: begin
				if (memBeatValid) begin
					beatCnt <= beatCnt + 3'h1;
					if (beatCnt == `ICSFP_LAST_BEAT) begin
						state <= S_REPLAY;
					end
				end
			end
			S_REPLAY: begin
				fetchValid <= 1'b1;
				state <= S_RUN;
			end
			default: begin
				state <= S_RUN;
			end
			endcase
			penCnt <= penNext;
			redirectValid <= penCnt == 2'h1 && !misNow;
			if (misNow) begin
				redirectPc <= updTaken ? updTarget
					: updPc + (updCompressed ? 32'h00000002 : 32'h00000004);
			end
			fetchReady <= (state == S_REPLAY || (state == S_RUN && !goFill))
				&& penNext == 2'h0;
		end
	end

	// scratchpad data port, allocation and release
	always @(posedge clk_sys) begin
		if (reset) begin
			spadLines <= 9'h000;
			dataBusy <= 1'b0;
			dataAck <= 1'b0;
			dataErr <= 1'b0;
			dataRdData <= 32'h00000000;
		end else if (dataAck) begin
			dataAck <= 1'b0;
			dataErr <= 1'b0;
			dataBusy <= 1'b0;
		end else if (dataBusy) begin
			dataAck <= 1'b1;
			dataRdData <= ramDout;
		end else if (dataTake) begin
			dataBusy <= 1'b1;
			dataErr <= !(dInSpad || dIsFree);
			if (dataWrite && dInSpad && dAlloc > spadLines) begin
				spadLines <= dAlloc;
			end else if (dataWrite && dIsFree && dataWrData == 32'h00000000) begin
				spadLines <= 9'h000;
			end
		end
	end

	// branch prediction tables
	reg  [30:0] btbPc  [0:BTB_N-1];
	reg  [30:0] btbTgt [0:BTB_N-1];
	reg  [BTB_N-1:0] btbV;
	reg  [BTB_N-1:0] btbRet;
	reg  [BTB_N-1:0] btbCond;
	reg  [4:0]  btbPtr;
	reg  [1:0]  branch_direction_table [0:BHT_N-1];
	reg  [31:0] ras [0:RAS_N-1];
	reg  [2:0]  rasTop;
	reg  [2:0]  rasCnt;
	reg         pHit;
	reg  [4:0]  pIdx;
	reg         uHit;
	reg  [4:0]  uIdx;
	integer     k;
	integer     j;

	// fully associative target lookup for predict and update
	always @* begin
		pHit = 1'b0;
		pIdx = 5'h00;
		uHit = 1'b0;
		uIdx = 5'h00;
		for (k = 0; k < BTB_N; k = k + 1) begin
			if (btbV[k] && btbPc[k] == predPc[31:1]) begin
				pHit = 1'b1;
				pIdx = k[4:0];
			end
			if (btbV[k] && btbPc[k] == updPc[31:1]) begin
				uHit = 1'b1;
				uIdx = k[4:0];
			end
		end
	end

	wire [2:0]  rasPrev = rasTop == 3'h0 ? RAS_LAST : rasTop - 3'h1;
	wire [2:0]  rasNext = rasTop == RAS_LAST ? 3'h0 : rasTop + 3'h1;
	wire [1:0]  pCtr    = branch_direction_table[predPc[BHT_W:1]];
	wire [1:0]  uCtr    = branch_direction_table[updPc[BHT_W:1]];
	wire        pUseRas = btbRet[pIdx] && rasCnt != 3'h0;
	wire [31:0] uLink   = updPc + (updCompressed ? 32'h00000002 : 32'h00000004);

	// prediction answered one cycle after the request
	always @(posedge clk_sys) begin
		if (reset) begin
			predValid <= 1'b0;
			predTaken <= 1'b0;
			predTarget <= 32'h00000000;
		end else begin
			predValid <= predReq;
			predTaken <= predReq && pHit && (btbCond[pIdx] ? pCtr[1] : 1'b1);
			predTarget <= pUseRas ? ras[rasPrev] : {btbTgt[pIdx], 1'b0};
		end
	end

	// training from resolved control flow
	always @(posedge clk_sys) begin
		if (reset) begin
			btbV <= {BTB_N{1'b0}};
			btbPtr <= 5'h00;
			rasTop <= 3'h0;
			rasCnt <= 3'h0;
			for (j = 0; j < BHT_N; j = j + 1) begin
				branch_direction_table[j] <= `ICSFP_BHT_INIT; // weakly not-taken start
			end
		end else if (updValid) begin
			if (updTaken) begin
				btbPc[uHit ? uIdx : btbPtr] <= updPc[31:1];
				btbTgt[uHit ? uIdx : btbPtr] <= updTarget[31:1];
				btbV[uHit ? uIdx : btbPtr] <= 1'b1;
				btbRet[uHit ? uIdx : btbPtr] <= updRet;
				btbCond[uHit ? uIdx : btbPtr] <= updCond;
				if (!uHit) begin
					btbPtr <= btbPtr == BTB_LAST ? 5'h00 : btbPtr + 5'h01;
				end
			end
			if (updCond && updTaken && uCtr != 2'h3) begin
				branch_direction_table[updPc[BHT_W:1]] <= uCtr + 2'h1;
			end else if (updCond && !updTaken && uCtr != 2'h0) begin
				branch_direction_table[updPc[BHT_W:1]] <= uCtr - 2'h1;
			end
			if (updCall) begin
				ras[rasTop] <= uLink;
				rasTop <= rasNext;
				rasCnt <= rasCnt == RAS_FULL ? RAS_FULL : rasCnt + 3'h1;
			end else if (updRet && rasCnt != 3'h0) begin
				rasTop <= rasPrev;
				rasCnt <= rasCnt - 3'h1;
			end
		end
	end
endmodule

// ---- verilog/icsfp_ram.v ----
`timescale 1ns/10ps
// single-port storage, byte lanes, registered read data
module icsfp_ram #(
	parameter AW = 12,
	parameter NB = 4
)(
	input  wire              clk_sys,
	input  wire              en,
	input  wire              we,
	input  wire [NB-1:0]     be,
	input  wire [AW-1:0]     addr,
	input  wire [NB*8-1:0]   wdata,
	output wire [NB*8-1:0]   rdata
);
	genvar g;
	generate
		for (g = 0; g < NB; g = g + 1) begin : g_lane
			reg [7:0] mem [0:(1<<AW)-1];
			reg [7:0] q;
			// one lane: write when enabled and its byte lane is set, read into q only when enabled without write
			always @(posedge clk_sys) begin
				if (en && we && be[g]) begin
					mem[addr] <= wdata[g*8+7:g*8];
				end else if (en && !we) begin
					q <= mem[addr];
				end
			end
			assign rdata[g*8+7:g*8] = q;
		end
	endgenerate
endmodule

// ---- verilog/icsfp_regs.vh ----
`ifndef ICSFP_REGS_VH
`define ICSFP_REGS_VH

// cache geometry: 16 KiB, two ways, 32-byte lines
`define ICSFP_CACHE_BYTES 16384
`define ICSFP_WAYS        2
`define ICSFP_LINE_BYTES  32
`define ICSFP_SETS        256
`define ICSFP_SET_LSB     5
`define ICSFP_SET_MSB     12
`define ICSFP_TAG_LSB     13
`define ICSFP_RAM_AW      12
`define ICSFP_BEATS       8
`define ICSFP_LAST_BEAT   3'h7

// scratchpad window, carved from way 1 only
`define ICSFP_SPAD_BASE   32'h10000000
`define ICSFP_SPAD_BYTES  32'h00002000
`define ICSFP_SPAD_WAY    1'b1

// executable window (plain default)
`define ICSFP_EXEC_BASE   32'h20000000
`define ICSFP_EXEC_LIMIT  32'h3FFFFFFF

// branch prediction sizes and timing
`define ICSFP_BTB_N       28
`define ICSFP_BHT_N       512
`define ICSFP_BHT_W       9
`define ICSFP_RAS_N       6
`define ICSFP_MISPRED_CYC 3
`define ICSFP_BHT_INIT    2'h1

`endif
